// file: cpm_cfg.svh
`ifndef CPM_CFG_SVH
`define CPM_CFG_SVH

// ==========================================================
// Register byte addresses
`define CPM_ADDR_PWR_KEY1 32'hffff0404
`define CPM_ADDR_PWR_CTRL 32'hffff0408
`define CPM_ADDR_PWR_KEY2 32'hffff040c
`define CPM_ADDR_CLK_KEY1 32'hffff0410
`define CPM_ADDR_CLK_CONF 32'hffff0414
`define CPM_ADDR_CLK_KEY2 32'hffff0418
`define CPM_ADDR_STATUS 32'hffff041c

// ==========================================================
// Key values
`define CPM_CLK_KEY1_VAL 16'h00aa
`define CPM_CLK_KEY2_VAL 16'h0055
`define CPM_PWR_KEY1_VAL 16'h0001
`define CPM_PWR_KEY2_VAL 16'h00f4

// ==========================================================
// Reset values
`define CPM_PWR_CTRL_RST 8'h03
`define CPM_CLK_CONF_RST 8'h21

// ==========================================================
// Field codes
`define CPM_SRC_PLL 2'h1
`define CPM_SRC_EXT 2'h3
`define CPM_DIV_CNT_W 7
`define CPM_DIV_ONE 8'h01

// ==========================================================
// Status register layout
`define CPM_ST_LOW_BIT 0
`define CPM_ST_WAKE_BIT 1
`define CPM_ST_PSEQ_LSB 2
`define CPM_ST_CSEQ_LSB 4
`define CPM_ST_MODE_LSB 6

`endif

// file: cpm_pkg.sv
package cpm_pkg;

  typedef enum logic [2:0] {
    CPM_MODE_NORMAL = 3'h0,
    CPM_MODE_PAUSE = 3'h1,
    CPM_MODE_NAP = 3'h2,
    CPM_MODE_SLEEP = 3'h3,
    CPM_MODE_STOP = 3'h4
  } cpm_mode_type;

  typedef enum logic [1:0] {
    CPM_KEY_IDLE = 2'h0,
    CPM_KEY_ARMED = 2'h1,
    CPM_KEY_LOADED = 2'h3
  } cpm_key_state_type;

  typedef enum logic [1:0] {
    CPM_PWR_RUN = 2'h0,
    CPM_PWR_LOW = 2'h1,
    CPM_PWR_WAKE = 2'h3
  } cpm_pwr_state_type;

  typedef struct packed {
    logic rsvd7;
    logic [2:0] mode;
    logic rsvd3;
    logic [2:0] div;
  } cpm_pwr_ctrl_type;

  typedef struct packed {
    logic [1:0] rsvd76;
    logic ref_internal;
    logic [2:0] rsvd42;
    logic [1:0] src;
  } cpm_clk_conf_type;

  typedef struct packed {
    logic core;
    logic periph;
    logic pll;
    logic xtal_timer;
    logic ext_irq;
  } cpm_domains_type;

  typedef struct packed {
    logic ref_internal;
    logic use_pll;
    logic use_ext_clock;
  } cpm_clk_sel_type;

endpackage

// file: cpm_key_seq.sv
`timescale 1ns/1ps
`include "cpm_cfg.svh"
module cpm_key_seq
  import cpm_pkg::*;
#(
  parameter logic [15:0] FIRST_KEY = 16'h0000,
  parameter logic [15:0] SECOND_KEY = 16'h0000
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic wr, // Any write to the block takes effect.
  input wire logic hit_first, // Write targets the first key.
  input wire logic hit_second, // Write targets the second key.
  input wire logic hit_data, // Write targets the protected register.
  input wire logic low_lanes, // Byte lanes 0 and 1 are enabled.
  input wire logic [15:0] wdata, // Write data, low half.
  output logic commit, // Pulse: protected register takes pending.
  output logic [7:0] pending, // Value waiting for the second key.
  output cpm_key_state_type state // Sequence state.
);

  cpm_key_state_type state_reg;
  cpm_key_state_type state_next;
  logic [7:0] pending_reg;
  logic first_ok;
  logic second_ok;

  assign first_ok = hit_first && low_lanes && (wdata == FIRST_KEY);
  assign second_ok = hit_second && low_lanes && (wdata == SECOND_KEY);
  assign commit = wr && (state_reg == CPM_KEY_LOADED) && second_ok;
  assign pending = pending_reg;
  assign state = state_reg;

  // ==========================================================
  // Sequence tracking
  // A first key write re-arms the sequence; any other write but the expected next step drops it.
  always_comb begin
    state_next = state_reg;
    if (wr) begin
      unique case (state_reg)
        CPM_KEY_IDLE: begin
          state_next = first_ok ? CPM_KEY_ARMED : CPM_KEY_IDLE;
        end
        CPM_KEY_ARMED: begin
          if (hit_data) begin
            state_next = CPM_KEY_LOADED;
          end else begin
            state_next = first_ok ? CPM_KEY_ARMED : CPM_KEY_IDLE;
          end
        end
        CPM_KEY_LOADED: begin
          state_next = first_ok ? CPM_KEY_ARMED : CPM_KEY_IDLE;
        end
        default: begin
          state_next = CPM_KEY_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CPM_KEY_IDLE;
    end else if (ce) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pending_reg <= 8'h00;
    end else if (ce && wr && hit_data && state_reg == CPM_KEY_ARMED) begin
      pending_reg <= wdata[7:0];
    end
  end

endmodule

// file: cpm_top.sv
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps
`include "cpm_cfg.svh"
// Contract
// - Clock configuration bit 5 picks the reference: 1 internal oscillator, 0 crystal.
// - Clock source field [1:0]: 01 selects PLL, 11 external clock pin.
// - Clock configuration changes only after key 0xAA, value, then key 0x55.
// - Power control changes only after key 0x01, value, then key 0xF4; a wake from low power also returns the mode field to normal without keys.
// - Operating mode field [6:4]: normal, pause, nap, sleep, stop; others reserved.
// - Sleep wakes on any external interrupt 0 to 3 or second timer.
// - Divider field [2:0] halves the core clock per step from code 0.
// - After reset the core runs from the PLL divided by eight.
// - Each mode powers its own set of domains, stop keeps only interrupts.
module cpm_top
  import cpm_pkg::*;
(
  input wire logic clk, // System clock, 40 MHz.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic ce, // Clock enable, freezes all state when low.
  input wire logic [31:0] wb_adr, // Wishbone byte address.
  input wire logic [31:0] wb_dat_w, // Wishbone write data.
  input wire logic [3:0] wb_sel, // Wishbone byte lane selects.
  input wire logic wb_we, // Wishbone write enable.
  input wire logic wb_cyc, // Wishbone cycle.
  input wire logic wb_stb, // Wishbone strobe.
  output logic [31:0] wb_dat_r, // Wishbone read data.
  output logic wb_ack, // Wishbone acknowledge.
  input wire logic [3:0] external_interrupt, // External interrupt events 0 to 3.
  input wire logic second_general_timer_evt, // Second timer event.
  input wire logic irq_any, // Any other enabled interrupt.
  output cpm_domains_type domains, // Power domain enables.
  output cpm_clk_sel_type clk_sel, // Clock reference and source select.
  output logic [2:0] core_divider, // Applied core divider code.
  output logic core_clk_en, // Core clock enable tick.
  output cpm_mode_type mode, // Operating mode now applied.
  output logic low_power // High while in a low power mode.
);

  // ==========================================================
  // Bus slave signals
  logic req;
  logic ack_reg;
  logic wr_fire;
  logic low_lanes;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic hit_pkey1;
  logic hit_pctrl;
  logic hit_pkey2;
  logic hit_ckey1;
  logic hit_cconf;
  logic hit_ckey2;
  logic hit_status;

  // ==========================================================
  // Register and state signals
  cpm_pwr_ctrl_type pwr_ctrl_reg;
  cpm_clk_conf_type clk_conf_reg;
  cpm_pwr_state_type pstate_reg;
  cpm_pwr_state_type pstate_next;
  cpm_domains_type domains_reg;
  cpm_domains_type domains_next;
  cpm_clk_sel_type clk_sel_reg;
  logic pwr_commit;
  logic clk_commit;
  logic [7:0] pwr_pending;
  logic [7:0] clk_pending;
  cpm_key_state_type pwr_seq_state;
  cpm_key_state_type clk_seq_state;
  cpm_pwr_ctrl_type pwr_new;
  cpm_clk_conf_type clk_new;
  logic wake;
  logic wake_clear;
  logic [`CPM_DIV_CNT_W-1:0] div_cnt_reg;
  logic [`CPM_DIV_CNT_W-1:0] div_mask;
  logic core_tick_reg;
  logic [31:0] status_word;

  // ==========================================================
  // Address decode
  assign req = wb_cyc && wb_stb;
  assign hit_pkey1 = (wb_adr == `CPM_ADDR_PWR_KEY1);
  assign hit_pctrl = (wb_adr == `CPM_ADDR_PWR_CTRL);
  assign hit_pkey2 = (wb_adr == `CPM_ADDR_PWR_KEY2);
  assign hit_ckey1 = (wb_adr == `CPM_ADDR_CLK_KEY1);
  assign hit_cconf = (wb_adr == `CPM_ADDR_CLK_CONF);
  assign hit_ckey2 = (wb_adr == `CPM_ADDR_CLK_KEY2);
  assign hit_status = (wb_adr == `CPM_ADDR_STATUS);
  assign low_lanes = wb_sel[0] && wb_sel[1];

  // Writes take effect on the edge at which the master sees ack.
  assign wr_fire = req && wb_we && ack_reg;

  // ==========================================================
  // Acknowledge, one cycle after the request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
    end else if (ce) begin
      ack_reg <= req && !ack_reg;
    end
  end

  assign wb_ack = ack_reg;

  // ==========================================================
  // Read data
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (hit_pctrl) begin
      rdata_next = {24'h00_0000, pwr_ctrl_reg};
    end else if (hit_cconf) begin
      rdata_next = {24'h00_0000, clk_conf_reg};
    end else if (hit_status) begin
      rdata_next = status_word;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 32'h0000_0000;
    end else if (ce && req && !wb_we && !ack_reg) begin
      rdata_reg <= rdata_next;
    end
  end

  assign wb_dat_r = rdata_reg;

  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`CPM_ST_LOW_BIT] = (pstate_reg == CPM_PWR_LOW);
    status_word[`CPM_ST_WAKE_BIT] = (pstate_reg == CPM_PWR_WAKE);
    status_word[`CPM_ST_PSEQ_LSB +: 2] = pwr_seq_state;
    status_word[`CPM_ST_CSEQ_LSB +: 2] = clk_seq_state;
    status_word[`CPM_ST_MODE_LSB +: 3] = pwr_ctrl_reg.mode;
  end

  // ==========================================================
  // Key sequences
  cpm_key_seq #(
    .FIRST_KEY(`CPM_CLK_KEY1_VAL),
    .SECOND_KEY(`CPM_CLK_KEY2_VAL)
  ) u_clk_keys (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(wr_fire),
    .hit_first(hit_ckey1),
    .hit_second(hit_ckey2),
    .hit_data(hit_cconf && wb_sel[0]),
    .low_lanes(low_lanes),
    .wdata(wb_dat_w[15:0]),
    .commit(clk_commit),
    .pending(clk_pending),
    .state(clk_seq_state)
  );

  cpm_key_seq #(
    .FIRST_KEY(`CPM_PWR_KEY1_VAL),
    .SECOND_KEY(`CPM_PWR_KEY2_VAL)
  ) u_pwr_keys (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .wr(wr_fire),
    .hit_first(hit_pkey1),
    .hit_second(hit_pkey2),
    .hit_data(hit_pctrl && wb_sel[0]),
    .low_lanes(low_lanes),
    .wdata(wb_dat_w[15:0]),
    .commit(pwr_commit),
    .pending(pwr_pending),
    .state(pwr_seq_state)
  );

  // ==========================================================
  // Clock configuration register
  // A reserved source code leaves the source field as it was.
  always_comb begin
    clk_new = clk_conf_reg;
    clk_new.rsvd76 = 2'h0;
    clk_new.rsvd42 = 3'h0;
    clk_new.ref_internal = clk_pending[5];
    if (clk_pending[1:0] == `CPM_SRC_PLL || clk_pending[1:0] == `CPM_SRC_EXT) begin
      clk_new.src = clk_pending[1:0];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_conf_reg <= `CPM_CLK_CONF_RST;
    end else if (ce && clk_commit) begin
      clk_conf_reg <= clk_new;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_reg <= '{ref_internal: 1'b1, use_pll: 1'b1, use_ext_clock: 1'b0};
    end else if (ce) begin
      clk_sel_reg.ref_internal <= clk_conf_reg.ref_internal;
      clk_sel_reg.use_pll <= (clk_conf_reg.src == `CPM_SRC_PLL);
      clk_sel_reg.use_ext_clock <= (clk_conf_reg.src == `CPM_SRC_EXT);
    end
  end

  assign clk_sel = clk_sel_reg;

  // ==========================================================
  // Power control register
  // A reserved mode code leaves the mode field as it was.
  always_comb begin
    pwr_new = pwr_ctrl_reg;
    pwr_new.rsvd7 = 1'b0;
    pwr_new.rsvd3 = 1'b0;
    pwr_new.div = pwr_pending[2:0];
    if (pwr_pending[6:4] <= CPM_MODE_STOP) begin
      pwr_new.mode = pwr_pending[6:4];
    end
  end

  // Leaving a low power mode returns the mode field to normal.
  assign wake_clear = (pstate_reg == CPM_PWR_LOW) && wake;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pwr_ctrl_reg <= `CPM_PWR_CTRL_RST;
    end else if (ce) begin
      if (pwr_commit) begin
        pwr_ctrl_reg <= pwr_new;
      end else if (wake_clear) begin
        pwr_ctrl_reg.mode <= CPM_MODE_NORMAL;
      end
    end
  end

  // ==========================================================
  // Wake sources per mode
  always_comb begin
    unique case (pwr_ctrl_reg.mode)
      CPM_MODE_PAUSE, CPM_MODE_NAP: begin
        wake = irq_any || (|external_interrupt) || second_general_timer_evt;
      end
      CPM_MODE_SLEEP: begin
        wake = (|external_interrupt) || second_general_timer_evt;
      end
      CPM_MODE_STOP: begin
        wake = |external_interrupt;
      end
      default: begin
        wake = 1'b1;
      end
    endcase
  end

  // ==========================================================
  // Power state machine
  always_comb begin
    pstate_next = pstate_reg;
    unique case (pstate_reg)
      CPM_PWR_RUN: begin
        if (pwr_ctrl_reg.mode != CPM_MODE_NORMAL) begin
          pstate_next = CPM_PWR_LOW;
        end
      end
      CPM_PWR_LOW: begin
        if (wake) begin
          pstate_next = CPM_PWR_WAKE;
        end
      end
      CPM_PWR_WAKE: begin
        pstate_next = CPM_PWR_RUN;
      end
      default: begin
        pstate_next = CPM_PWR_RUN;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pstate_reg <= CPM_PWR_RUN;
    end else if (ce) begin
      pstate_reg <= pstate_next;
    end
  end

  // ==========================================================
  // Power domains
  // The wake cycle restores everything but the core, which follows a cycle later.
  always_comb begin
    domains_next = '{core: 1'b1, periph: 1'b1, pll: 1'b1, xtal_timer: 1'b1, ext_irq: 1'b1};
    if (pstate_next == CPM_PWR_WAKE) begin
      domains_next.core = 1'b0;
    end else if (pstate_next == CPM_PWR_LOW) begin
      unique case (pwr_ctrl_reg.mode)
        CPM_MODE_PAUSE: begin
          domains_next.core = 1'b0;
        end
        CPM_MODE_NAP: begin
          domains_next.core = 1'b0;
          domains_next.periph = 1'b0;
        end
        CPM_MODE_SLEEP: begin
          domains_next.core = 1'b0;
          domains_next.periph = 1'b0;
          domains_next.pll = 1'b0;
        end
        CPM_MODE_STOP: begin
          domains_next.core = 1'b0;
          domains_next.periph = 1'b0;
          domains_next.pll = 1'b0;
          domains_next.xtal_timer = 1'b0;
        end
        default: begin
          domains_next.core = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      domains_reg <= '{core: 1'b1, periph: 1'b1, pll: 1'b1, xtal_timer: 1'b1, ext_irq: 1'b1};
    end else if (ce) begin
      domains_reg <= domains_next;
    end
  end

  assign domains = domains_reg;
  assign mode = cpm_mode_type'(pwr_ctrl_reg.mode);
  assign low_power = (pstate_reg == CPM_PWR_LOW);

  // ==========================================================
  // Core clock divider
  // Code n gives one enable tick every two to the n cycles.
  assign div_mask = `CPM_DIV_CNT_W'((`CPM_DIV_ONE << pwr_ctrl_reg.div) - `CPM_DIV_ONE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt_reg <= '0;
    end else if (ce) begin
      div_cnt_reg <= div_cnt_reg + `CPM_DIV_CNT_W'(1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_tick_reg <= 1'b0;
    end else if (ce) begin
      core_tick_reg <= domains_next.core && ((div_cnt_reg & div_mask) == div_mask);
    end
  end

  assign core_clk_en = core_tick_reg;
  assign core_divider = pwr_ctrl_reg.div;

endmodule

// file: cpm_top_sva.sv
`timescale 1ns/1ps
`include "cpm_cfg.svh"
module cpm_top_sva
  import cpm_pkg::*;
(
  input wire logic clk, // Clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic ce, // Clock enable.
  input wire logic [31:0] wb_adr, // Address.
  input wire logic wb_we, // Write enable.
  input wire logic wb_cyc, // Cycle.
  input wire logic wb_stb, // Strobe.
  input wire logic wb_ack, // Acknowledge.
  input wire logic [3:0] external_interrupt, // Wake events.
  input wire logic second_general_timer_evt, // Timer event.
  input wire cpm_domains_type domains, // Domain enables.
  input wire cpm_clk_sel_type clk_sel, // Clock select.
  input wire logic [2:0] core_divider, // Divider code.
  input wire cpm_mode_type mode, // Mode field.
  input wire logic low_power // Low power state.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [4:0] dom_exp;
  logic key_clk;
  logic key_pwr;
  // Domains expected for the applied mode while in the low power state.
  always_comb begin
    case (mode)
      CPM_MODE_PAUSE: dom_exp = 5'h0f;
      CPM_MODE_NAP: dom_exp = 5'h07;
      CPM_MODE_SLEEP: dom_exp = 5'h03;
      CPM_MODE_STOP: dom_exp = 5'h01;
      default: dom_exp = 5'h1f;
    endcase
  end
  assign key_clk = wb_ack && wb_we && wb_adr == `CPM_ADDR_CLK_KEY2;
  assign key_pwr = wb_ack && wb_we && wb_adr == `CPM_ADDR_PWR_KEY2;
  AST_ACK_ONE: assert property (wb_cyc && wb_stb && !wb_ack && ce |=> wb_ack)
    else $error("Request not acknowledged in the next cycle.");
  AST_ACK_DROP: assert property (wb_ack && ce |=> !wb_ack)
    else $error("Acknowledge longer than one cycle.");
  AST_RST_DEF: assert property ($rose(rst_n) |-> core_divider == 3'h3 && clk_sel == 3'h6)
    else $error("Wrong divider or clock select after reset.");
  AST_SEL_KEYED: assert property (!$stable(clk_sel) |-> $past(key_clk) || $past(key_clk, 2))
    else $error("Clock select changed without a second clock key.");
  AST_DIV_KEYED: assert property (!$stable(core_divider) |-> $past(key_pwr))
    else $error("Divider changed without a second power key.");
  AST_LOW_ENTRY: assert property (mode != CPM_MODE_NORMAL && !low_power && ce |=> low_power)
    else $error("Low power state not entered.");
  AST_DOMAINS: assert property (low_power |-> domains == dom_exp)
    else $error("Domain enables do not match the mode.");
  AST_SLEEP_WAKE: assert property (low_power && mode == CPM_MODE_SLEEP && ce &&
      (external_interrupt != 4'h0 || second_general_timer_evt) |=>
      !low_power && mode == CPM_MODE_NORMAL ##1 domains.core)
    else $error("Sleep did not wake on an event.");
  AST_STOP_HOLD: assert property (low_power && mode == CPM_MODE_STOP &&
      external_interrupt == 4'h0 |=> low_power)
    else $error("Stop left without an external interrupt.");
  AST_SLEEP_HOLD: assert property (low_power && mode == CPM_MODE_SLEEP &&
      external_interrupt == 4'h0 && !second_general_timer_evt |=> low_power)
    else $error("Sleep left without a wake event.");
endmodule
bind cpm_top cpm_top_sva i_cpm_top_sva (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_adr(wb_adr),
  .wb_we(wb_we), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_ack(wb_ack),
  .external_interrupt(external_interrupt), .second_general_timer_evt(second_general_timer_evt),
  .domains(domains), .clk_sel(clk_sel), .core_divider(core_divider), .mode(mode),
  .low_power(low_power));

// file: cpm_top_tb.sv
`timescale 1ns/1ps
`include "cpm_cfg.svh"
module cpm_top_tb
  import cpm_pkg::*;
;
  logic clk, rst_n, ce, wb_we, wb_cyc, wb_stb, wb_ack, core_clk_en, low_power, irq_any;
  logic [31:0] wb_adr, wb_dat_w, wb_dat_r;
  logic [3:0] wb_sel, external_interrupt;
  logic second_general_timer_evt;
  logic [2:0] core_divider;
  cpm_domains_type domains;
  cpm_clk_sel_type clk_sel;
  cpm_mode_type mode;
  int mismatches;
  int num_checks;
  cpm_top i_cpm_top (.clk(clk), .rst_n(rst_n), .ce(ce), .wb_adr(wb_adr), .wb_dat_w(wb_dat_w),
    .wb_sel(wb_sel), .wb_we(wb_we), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .external_interrupt(external_interrupt),
    .second_general_timer_evt(second_general_timer_evt), .irq_any(irq_any),
    .domains(domains), .clk_sel(clk_sel), .core_divider(core_divider),
    .core_clk_en(core_clk_en), .mode(mode), .low_power(low_power));
  // ====================================
  // Bus and check tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [31:0] a, input logic [31:0] d, input logic w,
      output logic [31:0] q);
    int n;
    logic got;
    n = 0;
    wb_adr <= a;
    wb_dat_w <= d;
    wb_we <= w;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    @(posedge clk);
    while (wb_ack !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    got = (wb_ack === 1'b1);
    q = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we <= 1'b0;
    @(posedge clk);
    if (!got) begin
      mismatches++;
      end_of_test();
    end
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(a, d, 1'b1, q);
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(a, 32'h0, 1'b0, q);
    chk(q, e);
  endtask
  task automatic pwr_seq(input logic [7:0] v);
    wr(`CPM_ADDR_PWR_KEY1, 32'h01);
    wr(`CPM_ADDR_PWR_CTRL, {24'h0, v});
    wr(`CPM_ADDR_PWR_KEY2, 32'hf4);
    repeat (2) @(posedge clk);
  endtask
  task automatic clk_seq(input logic [7:0] v);
    wr(`CPM_ADDR_CLK_KEY1, 32'haa);
    wr(`CPM_ADDR_CLK_CONF, {24'h0, v});
    wr(`CPM_ADDR_CLK_KEY2, 32'h55);
    @(posedge clk);
  endtask
  task automatic pulse(input int s, input int x);
    if (s == 0) irq_any <= 1'b1;
    else if (s == 1) second_general_timer_evt <= 1'b1;
    else external_interrupt[x] <= 1'b1;
    @(posedge clk);
    irq_any <= 1'b0;
    second_general_timer_evt <= 1'b0;
    external_interrupt <= 4'h0;
    repeat (3) @(posedge clk);
  endtask
  // ====================================
  // Scenarios
  task automatic t_reset();
    rd(`CPM_ADDR_PWR_CTRL, 32'h03);
    rd(`CPM_ADDR_CLK_CONF, 32'h21);
    chk(32'(clk_sel), 32'h6);
    chk(32'(core_divider), 32'h3);
    chk(32'(domains), 32'h1f);
    chk(32'(low_power), 32'h0);
  endtask
  task automatic t_keys();
    clk_seq(8'h03);
    chk(32'(clk_sel), 32'h1);
    rd(`CPM_ADDR_CLK_CONF, 32'h03);
    wr(`CPM_ADDR_CLK_KEY1, 32'haa);
    wr(`CPM_ADDR_CLK_CONF, 32'h21);
    wr(`CPM_ADDR_CLK_KEY2, 32'h54);
    wr(`CPM_ADDR_CLK_CONF, 32'h21);
    wr(`CPM_ADDR_CLK_KEY2, 32'h55);
    wr(`CPM_ADDR_CLK_KEY1, 32'haa);
    wr(`CPM_ADDR_CLK_CONF, 32'h21);
    wr(`CPM_ADDR_PWR_KEY1, 32'h01);
    wr(`CPM_ADDR_CLK_KEY2, 32'h55);
    rd(`CPM_ADDR_CLK_CONF, 32'h03);
    chk(32'(clk_sel), 32'h1);
    clk_seq(8'h20);
    chk(32'(clk_sel), 32'h5);
    rd(`CPM_ADDR_CLK_CONF, 32'h23);
    clk_seq(8'h01);
    chk(32'(clk_sel), 32'h2);
    rd(`CPM_ADDR_CLK_KEY1, 32'h0);
    wr(32'hffff0500, 32'hff);
    rd(32'hffff0500, 32'h0);
    // A key with only one low lane, or data without lane 0, breaks the sequence.
    wb_sel <= 4'h1;
    wr(`CPM_ADDR_CLK_KEY1, 32'haa);
    wb_sel <= 4'hf;
    wr(`CPM_ADDR_CLK_CONF, 32'h03);
    wr(`CPM_ADDR_CLK_KEY2, 32'h55);
    wr(`CPM_ADDR_CLK_KEY1, 32'haa);
    wb_sel <= 4'he;
    wr(`CPM_ADDR_CLK_CONF, 32'h03);
    wb_sel <= 4'hf;
    wr(`CPM_ADDR_CLK_KEY2, 32'h55);
    rd(`CPM_ADDR_CLK_CONF, 32'h01);
    chk(32'(clk_sel), 32'h2);
    wr(`CPM_ADDR_PWR_KEY1, 32'h01);
    wr(`CPM_ADDR_PWR_CTRL, 32'h07);
    wr(32'hffff0500, 32'h0);
    wr(`CPM_ADDR_PWR_KEY2, 32'hf4);
    rd(`CPM_ADDR_PWR_CTRL, 32'h03);
    pwr_seq(8'h53);
    rd(`CPM_ADDR_PWR_CTRL, 32'h03);
    chk(32'(low_power), 32'h0);
  endtask
  task automatic t_div();
    int n;
    for (int c = 0; c < 8; c++) begin
      pwr_seq(8'(c));
      rd(`CPM_ADDR_PWR_CTRL, 32'(c));
      chk(32'(core_divider), 32'(c));
      n = 0;
      repeat (256) begin
        @(posedge clk);
        if (core_clk_en === 1'b1) n++;
      end
      chk(32'(n >= (256 >> c) - 1 && n <= (256 >> c) + 1), 32'h1);
    end
  endtask
  // A request made while the clock enable is low waits, and nothing moves.
  task automatic t_ce();
    logic [31:0] q;
    logic v;
    int n;
    n = 0;
    ce <= 1'b0;
    wb_adr <= `CPM_ADDR_PWR_CTRL;
    wb_we <= 1'b0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    @(posedge clk);
    v = core_clk_en;
    repeat (8) begin
      @(posedge clk);
      if (wb_ack !== 1'b0 || core_clk_en !== v) n++;
    end
    chk(32'(n), 32'h0);
    ce <= 1'b1;
    xfer(`CPM_ADDR_PWR_CTRL, 32'h0, 1'b0, q);
    chk(q, 32'h07);
  endtask
  task automatic t_mode(input logic [2:0] m, input logic [4:0] dom, input logic [1:0] wk);
    pwr_seq({1'b0, m, 4'h3});
    chk(32'(low_power), 32'h1);
    chk(32'(mode), 32'(m));
    chk(32'(domains), 32'(dom));
    rd(`CPM_ADDR_STATUS, (32'(m) << `CPM_ST_MODE_LSB) | 32'h1);
    pulse(0, 0);
    chk(32'(low_power), 32'(!wk[0]));
    pulse(1, 0);
    chk(32'(low_power), 32'(wk == 2'b00));
    pulse(2, int'(m[1:0]));
    chk(32'(low_power), 32'h0);
    chk(32'(mode), 32'h0);
    chk(32'(domains), 32'h1f);
    rd(`CPM_ADDR_PWR_CTRL, 32'h03);
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    wb_adr = 32'h0;
    wb_dat_w = 32'h0;
    wb_sel = 4'hf;
    {wb_we, wb_cyc, wb_stb, irq_any, second_general_timer_evt} = 5'h0;
    external_interrupt = 4'h0;
    mismatches = 0;
    num_checks = 0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_keys();
    t_div();
    t_ce();
    t_mode(3'h1, 5'h0f, 2'b01);
    t_mode(3'h2, 5'h07, 2'b01);
    t_mode(3'h3, 5'h03, 2'b10);
    t_mode(3'h4, 5'h01, 2'b00);
    clk_seq(8'h01);
    pwr_seq(8'h05);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    end_of_test();
  end
endmodule
